// File: common/mseq_pkg.sv
// Constants for the microsequencer next-address block: widths, field
// positions in the microinstruction word, host register map, select codes.
// Assumes one 10 MHz sequencer clock shared by every user of this package.
package mseq_pkg;

   // Address and slice geometry
   localparam int SLICE_W = 4;
   localparam int N_SLICES = 3;
   localparam int ADDR_W = SLICE_W * N_SLICES;
   localparam int STACK_DEPTH = 4;
   localparam int SP_W = 2;

   // Microinstruction word layout
   localparam int WORD_W = 44;
   localparam int UNUSED_LSBS = 4;
   localparam int MODE_BIT = 43;
   localparam int SEQ_FIELD_LSB = 33;
   localparam int SEQ_FIELD_W = 3;
   localparam int POLARITY_BIT = 32;
   localparam int TEST_RESULT_BANK_BIT = 31;
   localparam int TEST_RESULT_SEL_LSB = 28;
   localparam int TEST_RESULT_SEL_W = 3;
   localparam int BRANCH_LSB = 4;

   // Host register map, byte wide, write only
   localparam logic [15:0] HOST_CMD_ADDR = 16'h3405;
   localparam logic [15:0] HOST_VEC_LO_ADDR = 16'h3406;
   localparam logic [15:0] HOST_VEC_HI_ADDR = 16'h3407;
   localparam int CMD_FORCE_BIT = 7;
   localparam int CMD_SLOW_BIT = 6;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [11:0] VECTOR_RESET = 12'h000;

   // Next-address source select codes
   typedef enum logic [1:0] {
      SRC_PC = 2'b00,
      SRC_BRANCH = 2'b01,
      SRC_STACK = 2'b10,
      SRC_VECTOR = 2'b11
   } src_sel_t;

   // Sequencer control field operations
   typedef enum logic [2:0] {
      OP_CONT = 3'b000,
      OP_JUMP = 3'b001,
      OP_CJUMP = 3'b010,
      OP_CCALL = 3'b011,
      OP_CALL = 3'b100,
      OP_RET = 3'b101,
      OP_CRET = 3'b110,
      OP_JVEC = 3'b111
   } seq_op_t;

   // Condition selector inputs, external bank (bank bit clear)
   localparam logic [2:0] CX_XREADY = 3'h0;
   localparam logic [2:0] CX_YREADY = 3'h1;
   localparam logic [2:0] CX_READY = 3'h2;
   localparam logic [2:0] CX_IFACE = 3'h3;
   localparam logic [2:0] CX_SLOW = 3'h4;
   localparam logic [2:0] CX_TRUE = 3'h5;
   // ALU bank (bank bit set)
   localparam logic [2:0] CA_ZERO = 3'h0;
   localparam logic [2:0] CA_CARRY = 3'h1;
   localparam logic [2:0] CA_NEG = 3'h2;
   localparam logic [2:0] CA_OVF = 3'h3;
   localparam logic [2:0] CA_LT = 3'h4;
   localparam logic [2:0] CA_LE = 3'h5;

endpackage

// File: common/seq_ctl_if.sv
// Control lines shared by the three sequencer slices.
// Driven by the control decode in the top module, read by every slice.
`timescale 1ns/1ps
interface seq_ctl_if;
   import mseq_pkg::*;
   src_sel_t src_sel;
   logic stack_hold_n;
   logic push_not_pop;
   logic pf_clear;
   logic addr_oe;

   modport ctl (output src_sel, stack_hold_n, push_not_pop, pf_clear,
      addr_oe);
   modport slice (input src_sel, stack_hold_n, push_not_pop, pf_clear,
      addr_oe);
endinterface // seq_ctl_if

// File: design/seq_slice.sv
// One 4-bit slice of the next-address sequencer: counter, branch latch,
// four-entry stack and source multiplexer. Cascade through carry ports.
// Assumes control lines and all data inputs come from the clk_sys domain.
`timescale 1ns/1ps
module seq_slice (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Shared control lines
   seq_ctl_if.slice ctl,
   // Data paths
   input wire logic [mseq_pkg::SLICE_W-1:0] vector_in,
   input wire logic [mseq_pkg::SLICE_W-1:0] branch_field_in,
   output logic [mseq_pkg::SLICE_W-1:0] addr_out,
   // Incrementer carry chain
   input wire logic carry_in,
   output logic carry_out
);
   import mseq_pkg::*;

   typedef struct packed {
      logic [SLICE_W-1:0] next_address_counter;
      logic [SLICE_W-1:0] branch_latch;
      logic [SP_W-1:0] sp;
      logic [STACK_DEPTH-1:0][SLICE_W-1:0] stack;
   } slice_state_t;

   slice_state_t state_reg;
   slice_state_t state_next;
   logic [SLICE_W-1:0] mux_out;
   logic [SP_W-1:0] sp_up;

   // Source multiplexer
   always_comb begin
      case (ctl.src_sel) // RULE2
         SRC_PC: mux_out = state_reg.next_address_counter;
         SRC_BRANCH: mux_out = state_reg.branch_latch;
         SRC_STACK: mux_out = state_reg.stack[state_reg.sp];
         SRC_VECTOR: mux_out = vector_in;
         default: mux_out = state_reg.next_address_counter;
      endcase
   end

   // Address held at zero while the output lines are released
   assign addr_out = ctl.addr_oe ? mux_out : '0; // RULE8
   assign carry_out = carry_in & (&mux_out); // RULE5
   assign sp_up = state_reg.sp + SP_W'(1);

   // Next state of counter, branch latch and stack
   always_comb begin
      state_next = state_reg;
      // Counter loads output address plus the cascaded carry
      state_next.next_address_counter =
         mux_out + {{(SLICE_W-1){1'b0}}, carry_in}; // RULE5
      // Branch field taken straight from the ROM outputs
      state_next.branch_latch = branch_field_in; // RULE6
      if (!ctl.stack_hold_n) begin // RULE3
         if (ctl.push_not_pop) begin
            // Pointer wraps, so a fifth push overwrites the oldest entry
            state_next.sp = sp_up; // RULE22
            state_next.stack[sp_up] =
               state_reg.next_address_counter; // RULE4
         end else begin
            // Popping past empty wraps; each further pop reads the entry one below
            state_next.sp = state_reg.sp - SP_W'(1); // RULE22
         end
      end
      if (ctl.pf_clear) begin
         state_next.next_address_counter = '0; // RULE21
         state_next.sp = '0; // RULE21
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule // seq_slice

// File: design/mseq_branch_ctl.sv
// Next-address and branch control of a microprogrammed memory controller:
// three cascaded sequencer slices, control decode, condition selection,
// host command and vector registers, and the 44-bit pipeline register.
// Assumes the microcode ROM is asynchronous and sits outside this block,
// the host write strobe and ALU flags are on clk_sys, and the ready flags
// and the power-fail line are asynchronous pins.
//
// Summary of operation
// RULE1 - Three 4-bit slices cascade into one 12-bit microinstruction address.
// RULE2 - Select 00 counter, 01 branch latch, 10 stack, 11 host vector.
// RULE3 - Stack holds on enable high; else push increments, pop decrements.
// RULE4 - Four-entry return stack filled from the counter, pointer on last.
// RULE5 - Counter loads output address plus one, carry spanning all slices.
// RULE6 - Branch field latched straight from ROM outputs, not the pipeline.
// RULE7 - Host loads the vector register feeding the direct inputs.
// RULE8 - Address lines driven continuously except during power-fail reset.
// RULE9 - Control decode uses sequencer field, forced jump and test result.
// RULE10 - Command write with bit seven set forces a jump to the vector.
// RULE11 - Without forced jump, CPU mode gives continue with stack unchanged.
// RULE12 - Polarity clear branches on true condition, set branches on false.
// RULE13 - Data-ready and ready flags resynchronised before the selectors.
// RULE14 - Host slow-sweep command bit is sensed as a branch condition.
// RULE15 - Less-than is negative XOR overflow; less-or-equal adds zero.
// RULE16 - Bit 31 picks the selector bank, bits 28 to 30 the input.
// RULE17 - Pipeline register loads the fetched word on each sequencer edge.
// RULE18 - Microinstruction is 44 bits wide, lowest four bits unused.
// RULE19 - Buffer data-available and interface ready feed the selectors.
// RULE20 - Word MSB set means sequencer operation, clear means CPU operation.
// RULE21 - Power-fail reset clears counter, stack pointer and pipeline.
// RULE22 - Full-stack push overwrites oldest; empty pop gives stable address. Here a pop always decrements the pointer, which wraps.
`timescale 1ns/1ps
module mseq_branch_ctl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Power-fail line from the supply monitor, asynchronous
   input wire logic power_fail_reset,
   // Host byte write port
   input wire logic host_wr_stb,
   input wire logic [15:0] host_addr,
   input wire logic [7:0] host_data,
   // Microcode ROM
   output logic [mseq_pkg::ADDR_W-1:0] micro_addr,
   output logic micro_addr_oe,
   input wire logic [mseq_pkg::WORD_W-1:0] rom_data,
   // Pipeline register to the rest of the controller
   output logic [mseq_pkg::WORD_W-1:0] pipe_word,
   // Asynchronous condition flags
   input wire logic x_data_ready,
   input wire logic y_data_ready,
   input wire logic ready,
   // Synchronous condition flags
   input wire logic output_iface_ready,
   input wire logic alu_zero,
   input wire logic alu_carry,
   input wire logic alu_neg,
   input wire logic alu_ovf,
   // Decoded state, registered
   output logic forced_jump_flag,
   output logic slow_timebase_flag
);
   import mseq_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] pipe;
      logic [7:0] cmd;
      logic [ADDR_W-1:0] vector;
      logic pf_sync;
      logic [1:0] xdr_sync;
      logic [1:0] ydr_sync;
      logic [1:0] rdy_sync;
      logic oe;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;

   seq_ctl_if ctl_bus ();

   // Decoded fields of the word on the pipeline outputs
   logic op_kind_bit;
   logic test_polarity_bit;
   logic test_result_bank;
   logic [TEST_RESULT_SEL_W-1:0] test_result_sel;
   seq_op_t seq_op;
   logic synced_x_data_ready;
   logic synced_y_data_ready;
   logic synced_ready;
   logic pf_active;
   logic [7:0] test_result_ext;
   logic [7:0] test_result_alu;
   logic test_result;
   logic take;
   logic alu_lt;
   logic alu_le;
   logic [N_SLICES:0] carry;

   // Second stages of the synchronisers are the only ones read
   assign synced_x_data_ready = state_reg.xdr_sync[1]; // RULE13
   assign synced_y_data_ready = state_reg.ydr_sync[1]; // RULE13
   assign synced_ready = state_reg.rdy_sync[1]; // RULE13
   // Enable flop is the inverted second power-fail stage
   assign pf_active = ~state_reg.oe;

   // Field decode of the current microinstruction
   assign op_kind_bit = state_reg.pipe[MODE_BIT]; // RULE20
   assign test_polarity_bit = state_reg.pipe[POLARITY_BIT];
   assign test_result_bank = state_reg.pipe[TEST_RESULT_BANK_BIT]; // RULE16
   assign test_result_sel =
      state_reg.pipe[TEST_RESULT_SEL_LSB +: TEST_RESULT_SEL_W]; // RULE16
   assign seq_op = seq_op_t'(state_reg.pipe[SEQ_FIELD_LSB +: SEQ_FIELD_W]);

   // Signed compares built from the ALU flags
   assign alu_lt = alu_neg ^ alu_ovf; // RULE15
   assign alu_le = alu_lt | alu_zero; // RULE15

   // External condition bank; unused inputs read false
   always_comb begin
      test_result_ext = 8'h00;
      test_result_ext[CX_XREADY] = synced_x_data_ready; // RULE19
      test_result_ext[CX_YREADY] = synced_y_data_ready; // RULE19
      test_result_ext[CX_READY] = synced_ready;
      test_result_ext[CX_IFACE] = output_iface_ready; // RULE19
      test_result_ext[CX_SLOW] = state_reg.cmd[CMD_SLOW_BIT]; // RULE14
      test_result_ext[CX_TRUE] = 1'b1;
   end

   // ALU condition bank
   always_comb begin
      test_result_alu = 8'h00;
      test_result_alu[CA_ZERO] = alu_zero;
      test_result_alu[CA_CARRY] = alu_carry;
      test_result_alu[CA_NEG] = alu_neg;
      test_result_alu[CA_OVF] = alu_ovf;
      test_result_alu[CA_LT] = alu_lt; // RULE15
      test_result_alu[CA_LE] = alu_le; // RULE15
   end

   // Only the bank named by the bank bit drives the test line
   assign test_result = test_result_bank ? test_result_alu[test_result_sel]
      : test_result_ext[test_result_sel]; // RULE16

   // Polarity: clear tests for true, set tests for false
   assign take = test_result ^ test_polarity_bit; // RULE12

   // Control decode standing in for the sequencer control ROM.
   // Priority: power fail, forced jump, CPU mode, then the field.
   always_comb begin
      ctl_bus.src_sel = SRC_PC;
      ctl_bus.stack_hold_n = 1'b1;
      ctl_bus.push_not_pop = 1'b0;
      ctl_bus.pf_clear = pf_active; // RULE21
      ctl_bus.addr_oe = state_reg.oe; // RULE8
      if (pf_active) begin
         ctl_bus.src_sel = SRC_PC;
      end else if (state_reg.cmd[CMD_FORCE_BIT]) begin
         ctl_bus.src_sel = SRC_VECTOR; // RULE10
      end else if (!op_kind_bit) begin
         ctl_bus.src_sel = SRC_PC; // RULE11
      end else begin
         case (seq_op) // RULE9
            OP_CONT: begin
               ctl_bus.src_sel = SRC_PC;
            end
            OP_JUMP: begin
               ctl_bus.src_sel = SRC_BRANCH;
            end
            OP_CJUMP: begin
               ctl_bus.src_sel = take ? SRC_BRANCH : SRC_PC;
            end
            OP_CCALL: begin
               if (take) begin
                  ctl_bus.src_sel = SRC_BRANCH;
                  ctl_bus.stack_hold_n = 1'b0;
                  ctl_bus.push_not_pop = 1'b1;
               end
            end
            OP_CALL: begin
               ctl_bus.src_sel = SRC_BRANCH;
               ctl_bus.stack_hold_n = 1'b0;
               ctl_bus.push_not_pop = 1'b1;
            end
            OP_RET: begin
               ctl_bus.src_sel = SRC_STACK;
               ctl_bus.stack_hold_n = 1'b0;
            end
            OP_CRET: begin
               if (take) begin
                  ctl_bus.src_sel = SRC_STACK;
                  ctl_bus.stack_hold_n = 1'b0;
               end
            end
            OP_JVEC: begin
               ctl_bus.src_sel = SRC_VECTOR;
            end
            default: begin
               ctl_bus.src_sel = SRC_PC;
            end
         endcase
      end
   end

   // Three slices, low slice first; carry in of one makes the increment
   assign carry[0] = 1'b1; // RULE5
   genvar gi;
   generate
      for (gi = 0; gi < N_SLICES; gi = gi + 1) begin : g_slice // RULE1
         seq_slice u_slice (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ctl(ctl_bus),
            .vector_in(state_reg.vector[gi*SLICE_W +: SLICE_W]), // RULE7
            .branch_field_in(
               rom_data[BRANCH_LSB + gi*SLICE_W +: SLICE_W]), // RULE6
            .addr_out(micro_addr[gi*SLICE_W +: SLICE_W]),
            .carry_in(carry[gi]),
            .carry_out(carry[gi+1])
         );
      end
   endgenerate

   // Next state of host registers, synchronisers and pipeline
   always_comb begin
      state_next = state_reg;
      // Two-stage synchronisers for pins from outside clk_sys
      state_next.pf_sync = power_fail_reset;
      state_next.xdr_sync = {state_reg.xdr_sync[0], x_data_ready};
      state_next.ydr_sync = {state_reg.ydr_sync[0], y_data_ready};
      state_next.rdy_sync = {state_reg.rdy_sync[0], ready};
      // Second power-fail stage, held inverted as the address enable
      state_next.oe = ~state_reg.pf_sync; // RULE8
      // Host writes; the command byte stays until rewritten by the host
      if (host_wr_stb) begin
         case (host_addr)
            HOST_CMD_ADDR: begin
               state_next.cmd = host_data; // RULE10
            end
            HOST_VEC_LO_ADDR: begin
               state_next.vector[7:0] = host_data; // RULE7
            end
            HOST_VEC_HI_ADDR: begin
               state_next.vector[ADDR_W-1:8] =
                  host_data[ADDR_W-9:0]; // RULE7
            end
            default: begin
               state_next.cmd = state_reg.cmd;
            end
         endcase
      end
      // Pipeline takes the fetched word on every sequencer edge outside power fail
      state_next.pipe = {rom_data[WORD_W-1:UNUSED_LSBS],
         {UNUSED_LSBS{1'b0}}}; // RULE17 RULE18
      if (pf_active) begin
         state_next.pipe = '0; // RULE21
      end
   end

   // State register; no async path, reset is synchronous
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg <= '0;
         state_reg.cmd <= CMD_RESET;
         state_reg.vector <= VECTOR_RESET;
         // Lines stay driven in reset; only power fail releases them
         state_reg.oe <= 1'b1; // RULE8
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs from flip-flops, except the mux address which must be live
   assign pipe_word = state_reg.pipe;
   assign micro_addr_oe = state_reg.oe;
   assign forced_jump_flag = state_reg.cmd[CMD_FORCE_BIT];
   assign slow_timebase_flag = state_reg.cmd[CMD_SLOW_BIT];

endmodule // mseq_branch_ctl

// File: bench/mseq_branch_monitor.sv
// Checker for the next-address block, bound to its top module.
// Assumes power-fail pulses last several clocks.
`timescale 1ns/1ps
module mseq_branch_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Watched ports
   input wire logic power_fail_reset,
   input wire logic host_wr_stb,
   input wire logic [15:0] host_addr,
   input wire logic [7:0] host_data,
   input wire logic [mseq_pkg::ADDR_W-1:0] micro_addr,
   input wire logic micro_addr_oe,
   input wire logic [mseq_pkg::WORD_W-1:0] rom_data,
   input wire logic [mseq_pkg::WORD_W-1:0] pipe_word,
   input wire logic forced_jump_flag,
   input wire logic slow_timebase_flag
);
   import mseq_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Pipeline and address relations
   a_low_bits_zero: assert property (pipe_word[3:0] == 4'h0)
      else $error("pipe low bits set");
   a_pipe_loads_rom: assert property ((!power_fail_reset)[*4]
      ##1 $past(nrst) |-> pipe_word == {$past(rom_data[43:4]), 4'h0})
      else $error("pipe missed rom word");
   a_cpu_continue: assert property ((!forced_jump_flag
      && !pipe_word[MODE_BIT] && micro_addr_oe)[*2]
      |-> micro_addr == $past(micro_addr) + 12'h001)
      else $error("cpu step not a continue");
   a_forced_holds: assert property (forced_jump_flag && micro_addr_oe
      && $past(forced_jump_flag) && $past(micro_addr_oe)
      && !$past(host_wr_stb) |-> $stable(micro_addr))
      else $error("forced address moved");
   // Host command latch
   a_force_latched: assert property (host_wr_stb
      && host_addr == HOST_CMD_ADDR
      |=> forced_jump_flag == $past(host_data[CMD_FORCE_BIT]))
      else $error("force bit not latched");
   a_slow_latched: assert property (host_wr_stb
      && host_addr == HOST_CMD_ADDR
      |=> slow_timebase_flag == $past(host_data[CMD_SLOW_BIT]))
      else $error("slow bit not latched");
   a_unmapped_keeps: assert property (host_wr_stb
      && host_addr != HOST_CMD_ADDR
      |=> $stable(forced_jump_flag) && $stable(slow_timebase_flag))
      else $error("flags moved on other write");
   // Power-fail behaviour
   a_pf_blanks: assert property (power_fail_reset[*3] ##1 1'b1
      |-> !micro_addr_oe && micro_addr == '0 && pipe_word == '0)
      else $error("outputs live in power fail");
   a_oe_restores: assert property ((!power_fail_reset)[*5]
      ##0 $past(nrst) |-> micro_addr_oe)
      else $error("address lines not driven");

   c_forced: cover property (forced_jump_flag);
   c_pf: cover property ($fell(micro_addr_oe));
   c_call: cover property (pipe_word[MODE_BIT]
      && pipe_word[SEQ_FIELD_LSB +: SEQ_FIELD_W] == OP_CALL);
endmodule // mseq_branch_monitor

bind mseq_branch_ctl mseq_branch_monitor u_mon (.clk_sys, .nrst,
   .power_fail_reset, .host_wr_stb, .host_addr, .host_data, .micro_addr,
   .micro_addr_oe, .rom_data, .pipe_word, .forced_jump_flag,
   .slow_timebase_flag);

// File: bench/host_model.sv
// Host processor model: byte writes to command and vector registers.
// Assumes callers run at the falling edge of clk_sys.
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk_sys,
   // Byte write port
   output logic host_wr_stb,
   output logic [15:0] host_addr,
   output logic [7:0] host_data
);
   initial begin
      host_wr_stb = 1'b0;
      host_addr = 16'h0000;
      host_data = 8'h00;
   end

   // One-cycle strobe; idle bus shows inverted values so stale data shows
   task automatic wr(input logic [15:0] addr, input logic [7:0] data);
      @(negedge clk_sys);
      host_wr_stb = 1'b1;
      host_addr = addr;
      host_data = data;
      @(negedge clk_sys);
      host_wr_stb = 1'b0;
      host_addr = ~addr;
      host_data = ~data;
   endtask
endmodule // host_model

// File: bench/microsequencer_branch_control_tb.sv
// Testbench for the next-address block with a table-driven microcode ROM.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module microsequencer_branch_control_tb;
   import mseq_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic power_fail_reset = 1'b0;
   logic x_data_ready = 1'b1;
   logic alu_neg = 1'b1;
   logic alu_ovf = 1'b0;
   logic y_data_ready, ready, output_iface_ready, alu_zero, alu_carry;
   logic host_wr_stb;
   logic [15:0] host_addr;
   logic [7:0] host_data;
   logic [ADDR_W-1:0] micro_addr;
   logic micro_addr_oe, forced_jump_flag, slow_timebase_flag;
   logic [WORD_W-1:0] rom_data, pipe_word;
   logic [WORD_W-1:0] rom [0:4095];
   logic [1:0] flags;
   logic [11:0] exp_seq [14] = '{12'h200, 12'h300, 12'h201, 12'h400,
      12'h401, 12'h500, 12'h501, 12'h502, 12'h600, 12'h700, 12'h701,
      12'h780, 12'h702, 12'h120};
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #50 clk_sys = ~clk_sys;
   // Asynchronous ROM sits on the address lines
   assign rom_data = rom[micro_addr];
   assign flags = {forced_jump_flag, slow_timebase_flag};

   host_model host (.clk_sys, .host_wr_stb, .host_addr, .host_data);
   mseq_branch_ctl dut (.clk_sys, .nrst, .power_fail_reset, .host_wr_stb,
      .host_addr, .host_data, .micro_addr, .micro_addr_oe, .rom_data,
      .pipe_word, .x_data_ready, .y_data_ready, .ready,
      .output_iface_ready, .alu_zero, .alu_carry, .alu_neg, .alu_ovf,
      .forced_jump_flag, .slow_timebase_flag);

   // Unused flags wander so their inputs are not tied; timeout guard
   always @(negedge clk_sys) begin
      cycles++;
      {y_data_ready, ready, output_iface_ready, alu_zero, alu_carry} <=
         cycles[6:2];
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end

   // Builds a word: mode, op, polarity, bank, condition, branch target
   function automatic logic [43:0] mw(input logic m, input logic [2:0] op,
      input logic pol, input logic bank, input logic [2:0] sel,
      input logic [11:0] br);
      return {m, 7'h00, op, pol, bank, sel, 12'h000, br, 4'h0};
   endfunction

   task automatic check(input logic [43:0] seen, input logic [43:0] exp,
      input string msg);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [11:0] a;
      for (int i = 0; i < 4096; i++)
         rom[i] = '0;
      rom[12'h120] = mw(1'b1, OP_JUMP, 1'b0, 1'b0, 3'h0, 12'h200);
      rom[12'h200] = mw(1'b1, OP_CALL, 1'b0, 1'b0, 3'h0, 12'h300);
      rom[12'h300] = mw(1'b1, OP_RET, 1'b0, 1'b0, 3'h0, 12'h000) | 44'hf;
      rom[12'h201] = mw(1'b1, OP_CJUMP, 1'b0, 1'b0, CX_TRUE, 12'h400);
      rom[12'h400] = mw(1'b1, OP_CJUMP, 1'b1, 1'b0, CX_TRUE, 12'h7ff);
      rom[12'h401] = mw(1'b1, OP_CJUMP, 1'b0, 1'b1, CA_LT, 12'h500);
      rom[12'h500] = mw(1'b0, OP_JUMP, 1'b0, 1'b0, 3'h0, 12'h7ff);
      rom[12'h502] = mw(1'b1, OP_CJUMP, 1'b0, 1'b0, CX_SLOW, 12'h600);
      rom[12'h600] = mw(1'b1, OP_CJUMP, 1'b0, 1'b0, CX_XREADY, 12'h700);
      rom[12'h701] = mw(1'b1, OP_CCALL, 1'b0, 1'b0, CX_TRUE, 12'h780);
      rom[12'h780] = mw(1'b1, OP_CRET, 1'b0, 1'b0, CX_TRUE, 12'h000);
      rom[12'h702] = mw(1'b1, OP_JVEC, 1'b0, 1'b0, 3'h0, 12'h000);
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      check(pipe_word, 44'h0, "pipe after reset");
      check(44'(flags), 44'h0, "flags");
      $display("test reset done");
      // Vector first, then force bit
      host.wr(HOST_VEC_LO_ADDR, 8'h20);
      host.wr(HOST_VEC_HI_ADDR, 8'h01);
      host.wr(HOST_CMD_ADDR, 8'h80);
      check(44'(micro_addr), 44'(12'h120), "forced address");
      host.wr(HOST_CMD_ADDR, 8'h40);
      check(44'(flags), 44'h1, "cmd");
      for (int i = 0; i < 14; i++) begin
         check(44'(micro_addr), 44'(exp_seq[i]),
            "branch trace");
         @(negedge clk_sys);
      end
      $display("test branching done");
      // Unmapped write must not touch the latch
      host.wr(16'h3404, 8'hff);
      check(44'(flags), 44'h1, "unmap");
      $display("test unmapped done");
      power_fail_reset = 1'b1;
      repeat (4) @(negedge clk_sys);
      check(44'({micro_addr_oe, micro_addr}), 44'h0, "pf address");
      check(pipe_word, 44'h0, "pf pipe");
      power_fail_reset = 1'b0;
      repeat (5) @(negedge clk_sys);
      check(44'(micro_addr_oe), 44'h1, "oe back");
      a = micro_addr;
      @(negedge clk_sys);
      check(44'(micro_addr), 44'(a + 12'h001), "increment");
      $display("test power fail done");
      stop_test();
   end
endmodule // microsequencer_branch_control_tb
